// ==== logic/dci_core.sv ====
`timescale 1ns/1ps
module dci_core #(
  parameter int FIFO_DEPTH = dci_pkg::TX_FIFO_DEPTH
) (
  input wire logic clk, // 40 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic rx_valid, // Received byte strobe from serial front end
  input wire logic [7:0] rx_data, // Received byte, framing already stripped
  output logic rx_ready, // Interpreter accepts a byte
  input wire logic read_protect_option, // Flash read protect programmed
  input wire logic brk_decoded, // CPU decoded a breakpoint instruction
  input wire logic [15:0] program_counter, // Current CPU program counter
  output logic tx_valid, // Reply byte available
  output logic [7:0] tx_data, // Reply byte
  input wire logic tx_ready, // Serial front end takes reply byte
  output logic pc_wr, // One-cycle program counter load
  output logic [15:0] pc_wdata, // Program counter load value
  output logic rf_wr, // One-cycle register file write
  output dci_pkg::dci_rf_wr_type rf_wr_bus, // Register file address and data
  output logic debug_mode_bit, // Device in debug mode
  output logic brk_enable, // Breakpoints enabled
  output logic dbg_ack, // Debug acknowledge bit
  output logic sys_reset_req // Device reset request bit
);

  // ****************************************************************
  // State
  // ****************************************************************
  dci_pkg::dci_state_type state_r, state_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [1:0] args_left_r, args_left_nxt;
  logic [15:0] arg_r, arg_nxt;
  logic [8:0] data_left_r, data_left_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic [15:0] reply_r, reply_nxt;
  logic [1:0] reply_cnt_r, reply_cnt_nxt;
  logic [7:0] debugger_control_reg_r, debugger_control_reg_nxt;
  logic [15:0] runtime_r, runtime_nxt;
  logic rx_ready_r, rx_ready_nxt;
  logic pc_wr_r, pc_wr_nxt;
  logic [15:0] pc_wdata_r, pc_wdata_nxt;
  logic rf_wr_r, rf_wr_nxt;
  dci_pkg::dci_rf_wr_type rf_bus_r, rf_bus_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;

  logic accept, dbg, full_access, overwrite_rt;
  logic [7:0] debugger_status_reg;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;

  function automatic logic is_reserved(input logic [7:0] code);
    return (code == dci_pkg::CMD_RSVD_A) || (code == dci_pkg::CMD_RSVD_B) ||
           (code >= dci_pkg::CMD_RSVD_FIRST);
  endfunction

  function automatic logic rf_write_ok(input logic in_dbg, input logic prot,
                                       input logic [11:0] a, input logic [7:0] d);
    logic in_flash;
    in_flash = (a >= dci_pkg::FLASH_REG_FIRST) && (a <= dci_pkg::FLASH_REG_LAST);
    return in_dbg && (!prot || (in_flash &&
           ((a != dci_pkg::FLASH_CMD_ADDR) || (d == dci_pkg::MASS_ERASE_CMD))));
  endfunction

  assign dbg = debugger_control_reg_r[dci_pkg::CTL_DEBUG_MODE_BIT];
  assign full_access = dbg && !read_protect_option;
  assign accept = rx_valid && rx_ready_r;

  always_comb begin
    debugger_status_reg = 8'h00;
    debugger_status_reg[dci_pkg::STAT_DEBUG_BIT] = dbg;
    debugger_status_reg[dci_pkg::STAT_PROTECT_BIT] = read_protect_option;
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    args_left_nxt = args_left_r;
    arg_nxt = arg_r;
    data_left_nxt = data_left_r;
    addr_nxt = addr_r;
    reply_nxt = reply_r;
    reply_cnt_nxt = reply_cnt_r;
    debugger_control_reg_nxt = debugger_control_reg_r;
    pc_wr_nxt = 1'b0;
    pc_wdata_nxt = pc_wdata_r;
    rf_wr_nxt = 1'b0;
    rf_bus_nxt = rf_bus_r;
    fifo_in_valid = 1'b0;
    overwrite_rt = 1'b0;
    unique case (state_r)
      dci_pkg::ST_IDLE: begin
        if (accept) begin
          cmd_nxt = rx_data;
          unique case (rx_data)
            dci_pkg::CMD_READ_REV: begin
              reply_nxt = {dci_pkg::REV_MAJOR, dci_pkg::REV_MINOR};
              reply_cnt_nxt = 2'h2;
              state_nxt = dci_pkg::ST_REPLY;
            end
            dci_pkg::CMD_READ_STAT: begin
              reply_nxt = {debugger_status_reg, 8'h00};
              reply_cnt_nxt = 2'h1;
              state_nxt = dci_pkg::ST_REPLY;
            end
            dci_pkg::CMD_READ_RUNTIME: begin
              if (dbg) begin
                reply_nxt = runtime_r;
                reply_cnt_nxt = 2'h2;
                state_nxt = dci_pkg::ST_REPLY;
              end
            end
            dci_pkg::CMD_WRITE_CTL: begin
              args_left_nxt = dci_pkg::ARGS_WRITE_CTL;
              state_nxt = dci_pkg::ST_ARGS;
            end
            dci_pkg::CMD_READ_CTL: begin
              reply_nxt = {debugger_control_reg_r, 8'h00};
              reply_cnt_nxt = 2'h1;
              state_nxt = dci_pkg::ST_REPLY;
            end
            dci_pkg::CMD_WRITE_PC: begin
              // Bytes are always consumed so the stream stays in step
              args_left_nxt = dci_pkg::ARGS_WRITE_PC;
              state_nxt = dci_pkg::ST_ARGS;
            end
            dci_pkg::CMD_READ_PC: begin
              reply_nxt = full_access ? program_counter : dci_pkg::PC_BLANK;
              reply_cnt_nxt = 2'h2;
              state_nxt = dci_pkg::ST_REPLY;
            end
            dci_pkg::CMD_WRITE_REG: begin
              args_left_nxt = dci_pkg::ARGS_WRITE_REG;
              state_nxt = dci_pkg::ST_ARGS;
              overwrite_rt = dbg;
            end
            default: begin
              // Reserved and unhandled codes are dropped without reply
              state_nxt = dci_pkg::ST_IDLE;
            end
          endcase
        end
      end
      dci_pkg::ST_ARGS: begin
        if (accept) begin
          arg_nxt = {arg_r[7:0], rx_data};
          args_left_nxt = args_left_r - 2'h1;
          if (args_left_r == 2'h1) begin
            state_nxt = dci_pkg::ST_IDLE;
            if (cmd_r == dci_pkg::CMD_WRITE_CTL) begin
              debugger_control_reg_nxt = rx_data & dci_pkg::CTL_WRITE_MASK;
              if (read_protect_option && dbg) begin
                debugger_control_reg_nxt[dci_pkg::CTL_DEBUG_MODE_BIT] = 1'b1;
              end
            end else if (cmd_r == dci_pkg::CMD_WRITE_PC) begin
              pc_wr_nxt = full_access;
              pc_wdata_nxt = {arg_r[7:0], rx_data};
            end else begin
              // High nibble of the first address byte is ignored
              addr_nxt = {arg_r[11:8], arg_r[7:0]};
              data_left_nxt = (rx_data == 8'h00) ? dci_pkg::REG_SIZE_FULL
                                                 : {1'b0, rx_data};
              state_nxt = dci_pkg::ST_DATA;
            end
          end
        end
      end
      dci_pkg::ST_DATA: begin
        if (accept) begin
          rf_wr_nxt = rf_write_ok(dbg, read_protect_option, addr_r, rx_data);
          rf_bus_nxt.addr = addr_r;
          rf_bus_nxt.data = rx_data;
          addr_nxt = addr_r + 12'h001;
          data_left_nxt = data_left_r - 9'h001;
          if (data_left_r == 9'h001) begin
            state_nxt = dci_pkg::ST_IDLE;
          end
        end
      end
      dci_pkg::ST_REPLY: begin
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          reply_nxt = {reply_r[7:0], 8'h00};
          reply_cnt_nxt = reply_cnt_r - 2'h1;
          if (reply_cnt_r == 2'h1) begin
            state_nxt = dci_pkg::ST_IDLE;
          end
        end
      end
    endcase
    if (brk_decoded && debugger_control_reg_r[dci_pkg::CTL_BRK_EN_BIT]) begin
      debugger_control_reg_nxt[dci_pkg::CTL_DEBUG_MODE_BIT] = 1'b1;
    end
    rx_ready_nxt = (state_nxt != dci_pkg::ST_REPLY);
  end

  // ****************************************************************
  // Runtime counter
  // ****************************************************************
  always_comb begin
    runtime_nxt = runtime_r;
    if (overwrite_rt) begin
      runtime_nxt = dci_pkg::RUNTIME_RESET;
    end else if (dbg && !debugger_control_reg_nxt[dci_pkg::CTL_DEBUG_MODE_BIT]) begin
      runtime_nxt = dci_pkg::RUNTIME_RESET;
    end else if (!dbg && (runtime_r != dci_pkg::RUNTIME_MAX)) begin
      runtime_nxt = runtime_r + 16'h0001;
    end
  end

  // ****************************************************************
  // Reply output stage
  // ****************************************************************
  // Extra stage keeps tx outputs on flops at the cost of one cycle
  assign fifo_out_ready = !tx_valid_r || tx_ready;

  always_comb begin
    tx_valid_nxt = tx_valid_r;
    tx_data_nxt = tx_data_r;
    if (fifo_out_ready) begin
      tx_valid_nxt = fifo_out_valid;
      tx_data_nxt = fifo_out_valid ? fifo_out_data : tx_data_r;
    end
  end

  dci_fifo #(
    .WIDTH(dci_pkg::BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(reply_r[15:8]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= dci_pkg::ST_IDLE;
      cmd_r <= 8'h00;
      args_left_r <= 2'h0;
      arg_r <= 16'h0000;
      data_left_r <= 9'h000;
      addr_r <= 12'h000;
      reply_r <= 16'h0000;
      reply_cnt_r <= 2'h0;
      debugger_control_reg_r <= dci_pkg::CTL_RESET_VAL;
      runtime_r <= dci_pkg::RUNTIME_RESET;
      rx_ready_r <= 1'b1;
      pc_wr_r <= 1'b0;
      pc_wdata_r <= 16'h0000;
      rf_wr_r <= 1'b0;
      rf_bus_r <= '0;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      args_left_r <= args_left_nxt;
      arg_r <= arg_nxt;
      data_left_r <= data_left_nxt;
      addr_r <= addr_nxt;
      reply_r <= reply_nxt;
      reply_cnt_r <= reply_cnt_nxt;
      debugger_control_reg_r <= debugger_control_reg_nxt;
      runtime_r <= runtime_nxt;
      rx_ready_r <= rx_ready_nxt;
      pc_wr_r <= pc_wr_nxt;
      pc_wdata_r <= pc_wdata_nxt;
      rf_wr_r <= rf_wr_nxt;
      rf_bus_r <= rf_bus_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_data_r <= tx_data_nxt;
    end
  end

  assign rx_ready = rx_ready_r;
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign pc_wr = pc_wr_r;
  assign pc_wdata = pc_wdata_r;
  assign rf_wr = rf_wr_r;
  assign rf_wr_bus = rf_bus_r;
  assign debug_mode_bit = debugger_control_reg_r[dci_pkg::CTL_DEBUG_MODE_BIT];
  assign brk_enable = debugger_control_reg_r[dci_pkg::CTL_BRK_EN_BIT];
  assign dbg_ack = debugger_control_reg_r[dci_pkg::CTL_DBGACK_BIT];
  assign sys_reset_req = debugger_control_reg_r[dci_pkg::CTL_RESET_BIT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  rev_reply_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == dci_pkg::ST_IDLE && accept && rx_data == dci_pkg::CMD_READ_REV) |=>
    (state_r == dci_pkg::ST_REPLY && reply_cnt_r == 2'h2 &&
     reply_r == {dci_pkg::REV_MAJOR, dci_pkg::REV_MINOR}))
    else $error("revision reply wrong");

  stat_reply_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == dci_pkg::ST_IDLE && accept && rx_data == dci_pkg::CMD_READ_STAT) |=>
    (reply_cnt_r == 2'h1 && reply_r[15:8] == $past(debugger_status_reg)))
    else $error("status reply wrong");

  runtime_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!dbg && runtime_r == dci_pkg::RUNTIME_MAX) |=> (runtime_r == dci_pkg::RUNTIME_MAX))
    else $error("runtime counter wrapped");

  runtime_step_a: assert property (@(posedge clk) disable iff (rst)
    (!dbg && runtime_r != dci_pkg::RUNTIME_MAX) |=> (runtime_r == $past(runtime_r) + 16'h0001))
    else $error("runtime counter did not count");

  normal_gate_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == dci_pkg::ST_IDLE && accept && !dbg &&
     rx_data == dci_pkg::CMD_READ_RUNTIME) |=> (state_r == dci_pkg::ST_IDLE))
    else $error("runtime read acted outside debug mode");

  protect_keep_a: assert property (@(posedge clk) disable iff (rst)
    (read_protect_option && debug_mode_bit) |=> debug_mode_bit)
    else $error("debug mode cleared under read protect");

  ctl_write_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == dci_pkg::ST_ARGS && cmd_r == dci_pkg::CMD_WRITE_CTL && accept &&
     !read_protect_option && !brk_decoded) |=>
    (debugger_control_reg_r == ($past(rx_data) & dci_pkg::CTL_WRITE_MASK)))
    else $error("control write not loaded");

  pc_block_a: assert property (@(posedge clk) disable iff (rst)
    pc_wr_r |-> $past(full_access))
    else $error("program counter written while blocked");

  pc_blank_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == dci_pkg::ST_IDLE && accept && rx_data == dci_pkg::CMD_READ_PC &&
     !full_access) |=> (reply_r == dci_pkg::PC_BLANK))
    else $error("blocked program counter read not all ones");

  size_load_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == dci_pkg::ST_ARGS && cmd_r == dci_pkg::CMD_WRITE_REG && accept &&
     args_left_r == 2'h1) |=> (state_r == dci_pkg::ST_DATA && data_left_r ==
     (($past(rx_data) == 8'h00) ? dci_pkg::REG_SIZE_FULL : {1'b0, $past(rx_data)})))
    else $error("register write size wrong");

  rf_gate_a: assert property (@(posedge clk) disable iff (rst)
    rf_wr_r |-> $past(dbg))
    else $error("register write outside debug mode");

  mass_erase_a: assert property (@(posedge clk) disable iff (rst)
    (rf_wr_r && $past(read_protect_option)) |->
    (rf_bus_r.addr >= dci_pkg::FLASH_REG_FIRST &&
     (rf_bus_r.addr != dci_pkg::FLASH_CMD_ADDR || rf_bus_r.data == dci_pkg::MASS_ERASE_CMD)))
    else $error("protected register write let through");

  reserved_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == dci_pkg::ST_IDLE && accept && is_reserved(rx_data)) |=>
    (state_r == dci_pkg::ST_IDLE && rx_ready_r))
    else $error("reserved code acted on");

endmodule

// ==== logic/dci_fifo.sv ====
`timescale 1ns/1ps
module dci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic in_valid, // Write request
  output logic in_ready, // Room available
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Data available
  input wire logic out_ready, // Drain request
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic do_wr, do_rd;

  // Extra pointer bit separates full from empty
  assign in_ready = !((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];

  always_comb begin
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    wr_ptr_nxt = do_wr ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = do_rd ? rd_ptr_r + 1'b1 : rd_ptr_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
    if (do_wr) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end
endmodule

// ==== logic/dci_pkg.sv ====
package dci_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_READ_REV = 8'h00;
  localparam logic [7:0] CMD_READ_STAT = 8'h02;
  localparam logic [7:0] CMD_READ_RUNTIME = 8'h03;
  localparam logic [7:0] CMD_WRITE_CTL = 8'h04;
  localparam logic [7:0] CMD_READ_CTL = 8'h05;
  localparam logic [7:0] CMD_WRITE_PC = 8'h06;
  localparam logic [7:0] CMD_READ_PC = 8'h07;
  localparam logic [7:0] CMD_WRITE_REG = 8'h08;
  localparam logic [7:0] CMD_RSVD_A = 8'h01;
  localparam logic [7:0] CMD_RSVD_B = 8'h0F;
  localparam logic [7:0] CMD_RSVD_FIRST = 8'h13;

  // ****************************************************************
  // Control and status layout
  // ****************************************************************
  localparam int CTL_DEBUG_MODE_BIT = 7;
  localparam int CTL_BRK_EN_BIT = 6;
  localparam int CTL_DBGACK_BIT = 5;
  localparam int CTL_RESET_BIT = 0;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hE1;
  localparam logic [7:0] CTL_RESET_VAL = 8'h00;
  localparam int STAT_DEBUG_BIT = 7;
  localparam int STAT_PROTECT_BIT = 6;

  // Revision value is arbitrary
  localparam logic [7:0] REV_MAJOR = 8'h01;
  localparam logic [7:0] REV_MINOR = 8'h00;

  // ****************************************************************
  // Values and counts
  // ****************************************************************
  localparam logic [15:0] RUNTIME_MAX = 16'hFFFF;
  localparam logic [15:0] PC_BLANK = 16'hFFFF;
  localparam logic [15:0] RUNTIME_RESET = 16'h0000;
  localparam logic [1:0] ARGS_WRITE_CTL = 2'h1;
  localparam logic [1:0] ARGS_WRITE_PC = 2'h2;
  localparam logic [1:0] ARGS_WRITE_REG = 2'h3;
  localparam logic [8:0] REG_SIZE_FULL = 9'h100;
  localparam logic [11:0] FLASH_REG_FIRST = 12'hFF8;
  localparam logic [11:0] FLASH_REG_LAST = 12'hFFF;
  localparam logic [11:0] FLASH_CMD_ADDR = 12'hFF8;
  localparam logic [7:0] MASS_ERASE_CMD = 8'h63;
  localparam int BYTE_W = 8;
  localparam int TX_FIFO_DEPTH = 16;

  typedef enum logic [1:0] {ST_IDLE, ST_ARGS, ST_DATA, ST_REPLY} dci_state_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
  } dci_rf_wr_type;

endpackage

// ==== tb/dci_core_bench.sv ====
`timescale 1ns/1ps
module dci_core_bench;
  logic clk, rst, rx_valid, rx_ready, prot, brk, tx_valid, tx_ready, stall;
  logic pc_wr, rf_wr, dbg, brk_en, ack, sreq;
  logic [7:0] rx_data, tx_data;
  logic [15:0] pc, pc_wdata;
  dci_pkg::dci_rf_wr_type rf_bus, last_wr;
  int mismatches, compares, cycles, n_pc, n_rf;
  logic [7:0] d[$];
  dci_core i_dut (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .read_protect_option(prot), .brk_decoded(brk),
    .program_counter(pc), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .pc_wr(pc_wr), .pc_wdata(pc_wdata), .rf_wr(rf_wr), .rf_wr_bus(rf_bus),
    .debug_mode_bit(dbg), .brk_enable(brk_en), .dbg_ack(ack), .sys_reset_req(sreq));
  dci_host_model i_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .stall(stall));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Saturation wait dominates the run time
  always @(posedge clk) begin
    cycles++;
    if (pc_wr) n_pc++;
    if (rf_wr) begin
      n_rf++;
      last_wr = rf_bus;
    end
    if (cycles == 90000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reply(input string what, input int n, input logic [15:0] exp);
    logic [15:0] v;
    int t;
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      t = 0;
      while (i_host.got_q.size() == 0 && t < 100) begin
        @(posedge clk);
        t++;
      end
      v = {v[7:0], (t < 100) ? i_host.got_q.pop_front() : 8'hXX};
    end
    chk(what, {4'h0, exp}, {4'h0, v});
  endtask
  task automatic none(input string what);
    repeat (12) @(posedge clk);
    chk(what, 20'h00000, 20'(i_host.got_q.size()));
  endtask
  task automatic t_normal();
    i_host.xfer('{8'h80});
    none("autobaud byte");
    d = '{8'h01, 8'h0F, 8'h13, 8'hFF};
    foreach (d[i]) begin
      i_host.xfer('{d[i]});
      none("reserved code");
    end
    i_host.xfer('{8'h00});
    reply("revision", 2, {dci_pkg::REV_MAJOR, dci_pkg::REV_MINOR});
    i_host.xfer('{8'h02});
    reply("status", 1, 16'h0000);
    i_host.xfer('{8'h03});
    none("runtime outside debug");
    i_host.xfer('{8'h07});
    reply("pc outside debug", 2, 16'hFFFF);
    i_host.xfer('{8'h06, 8'h12, 8'h34});
    none("pc write reply");
    chk("pc write outside debug", 20'h0, 20'(n_pc));
    i_host.xfer('{8'h08, 8'h00, 8'h10, 8'h01, 8'hAA});
    none("reg write reply");
    chk("reg write outside debug", 20'h0, 20'(n_rf));
  endtask
  task automatic t_debug();
    i_host.xfer('{8'h04, 8'hFF});
    i_host.xfer('{8'h05});
    reply("control masked", 1, 16'h00E1);
    chk("reset and ack bits", 20'h3, {18'h0, sreq, ack});
    i_host.xfer('{8'h04, 8'h80});
    i_host.xfer('{8'h02});
    reply("status debug", 1, 16'h0080);
    i_host.xfer('{8'h06, 8'h12, 8'h34});
    none("pc write reply");
    chk("pc write", 20'h11234, {3'h0, 1'(n_pc), pc_wdata});
    i_host.xfer('{8'h07});
    reply("pc read", 2, 16'hABCD);
    i_host.xfer('{8'h08, 8'h00, 8'hFE, 8'h02, 8'h11, 8'h22});
    none("reg write reply");
    chk("reg write", 20'h0FF22, last_wr);
    chk("reg write count", 20'h2, 20'(n_rf));
    i_host.xfer('{8'h03});
    reply("runtime cleared", 2, 16'h0000);
    d = '{8'h08, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 256; i++) d.push_back(8'(i));
    i_host.xfer(d);
    none("full reg write reply");
    chk("size zero count", 20'h102, 20'(n_rf));
  endtask
  task automatic t_runtime();
    i_host.xfer('{8'h04, 8'h40});
    chk("run with breaks", 20'h1, {18'h0, dbg, brk_en});
    repeat (66000) @(negedge clk);
    brk = 1'b1;
    @(negedge clk);
    brk = 1'b0;
    i_host.xfer('{8'h03});
    reply("runtime saturated", 2, 16'hFFFF);
  endtask
  task automatic t_protect();
    @(negedge clk);
    prot = 1'b1;
    i_host.xfer('{8'h04, 8'h40});
    chk("debug kept", 20'h1, {19'h0, dbg});
    i_host.xfer('{8'h02});
    reply("status protect", 1, 16'h00C0);
    i_host.xfer('{8'h07});
    reply("pc protected", 2, 16'hFFFF);
    i_host.xfer('{8'h06, 8'h55, 8'h66});
    i_host.xfer('{8'h08, 8'h00, 8'h10, 8'h01, 8'hAA});
    i_host.xfer('{8'h08, 8'h0F, 8'hF8, 8'h01, 8'h55});
    none("protected writes reply");
    chk("protected writes", 20'h10102, {3'h0, 1'(n_pc), 16'(n_rf)});
    i_host.xfer('{8'h08, 8'h0F, 8'hF8, 8'h01, 8'h63});
    none("erase reply");
    chk("mass erase", 20'hFF863, last_wr);
  endtask
  task automatic t_fifo();
    stall = 1'b1;
    d = {};
    repeat (11) d.push_back(8'h00);
    fork
      i_host.xfer(d);
      begin
        repeat (80) @(negedge clk);
        chk("stalled intake", 20'h0, {19'h0, rx_ready});
        stall = 1'b0;
      end
    join
    repeat (11) reply("buffered revision", 2, 16'h0100);
  endtask
  initial begin
    rst = 1'b1;
    prot = 1'b0;
    brk = 1'b0;
    stall = 1'b0;
    pc = 16'hABCD;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_normal();
    t_debug();
    t_runtime();
    t_protect();
    t_fifo();
    end_of_test();
  end
endmodule

// ==== tb/dci_host_model.sv ====
`timescale 1ns/1ps
module dci_host_model (
  input wire logic clk, // System clock
  output logic rx_valid, // Byte offered
  output logic [7:0] rx_data, // Offered byte
  input wire logic rx_ready, // Byte taken
  input wire logic tx_valid, // Reply offered
  input wire logic [7:0] tx_data, // Reply byte
  output logic tx_ready, // Reply taken
  input wire logic stall // Slow host
);
  logic [7:0] got_q[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    tx_ready = 1'b0;
  end
  always @(negedge clk) tx_ready <= !stall;
  always @(posedge clk) if (tx_valid && tx_ready) got_q.push_back(tx_data);
  // Command byte first, arguments after, each held until taken
  task automatic xfer(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = q[i];
      // Ready is a flop, so its level before the edge decides the take
      while (!rx_ready) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    // Released line must not repeat the last byte
    rx_data = ~rx_data;
  endtask
endmodule
